// File: port_edge_interrupts.sv
`timescale 1ns/1ps
`include "port_edge_regs.svh"
module port_edge_interrupts (
    input wire logic clk,
    input wire logic rst_b,
    input wire port_edge_pkg::port_ctrl_t first_ctrl,
    input wire port_edge_pkg::port_ctrl_t second_ctrl,
    input wire logic [7:0] first_shared_port_pins_in,
    input wire logic [7:0] second_shared_port_pins_in,
    input wire logic [7:0] port7_pins_in,
    input wire logic single_pin_rising_sel,
    input wire port_edge_pkg::irq_flags_t irq_clear,
    output logic [7:0] first_shared_port_pins_out,
    output logic [7:0] first_shared_port_pins_oe_b,
    output logic [7:0] second_shared_port_pins_out,
    output logic [7:0] second_shared_port_pins_oe_b,
    output logic [7:0] first_port_read,
    output logic [7:0] second_port_read,
    output logic [7:0] port7_read,
    output port_edge_pkg::irq_flags_t irq_flags
);
    import port_edge_pkg::*;

    logic [7:0] first_sync;
    logic [7:0] second_sync;
    logic [7:0] p7_sync;
    logic [7:0] p7_prev_r;
    logic low_hit;
    logic mid_hit;
    logic single_hit;
    logic low_flag;
    logic mid_flag;
    logic single_flag;

    // Segment select wins over port direction on every pin
    shared_pin_drive #(
        .WIDTH(`PORT_WIDTH)
    ) first_drive_i (
        .clk(clk),
        .rst_b(rst_b),
        .dir_out(first_ctrl.dir_out),
        .lcd_sel(first_ctrl.lcd_sel),
        .data_out(first_ctrl.data_out),
        .seg_drive(first_ctrl.seg_drive),
        .pins_out_r(first_shared_port_pins_out),
        .pins_oe_b_r(first_shared_port_pins_oe_b)
    );

    shared_pin_drive #(
        .WIDTH(`PORT_WIDTH)
    ) second_drive_i (
        .clk(clk),
        .rst_b(rst_b),
        .dir_out(second_ctrl.dir_out),
        .lcd_sel(second_ctrl.lcd_sel),
        .data_out(second_ctrl.data_out),
        .seg_drive(second_ctrl.seg_drive),
        .pins_out_r(second_shared_port_pins_out),
        .pins_oe_b_r(second_shared_port_pins_oe_b)
    );

    // Pins are asynchronous; they idle high through pull-ups
    pin_sync2 #(
        .WIDTH(`PORT_WIDTH),
        .RESET_VALUE(`PIN_RESET_VALUE)
    ) first_sync_i (
        .clk(clk),
        .rst_b(rst_b),
        .pins_async(first_shared_port_pins_in),
        .sync_r(first_sync)
    );

    pin_sync2 #(
        .WIDTH(`PORT_WIDTH),
        .RESET_VALUE(`PIN_RESET_VALUE)
    ) second_sync_i (
        .clk(clk),
        .rst_b(rst_b),
        .pins_async(second_shared_port_pins_in),
        .sync_r(second_sync)
    );

    pin_sync2 #(
        .WIDTH(`PORT_WIDTH),
        .RESET_VALUE(`PIN_RESET_VALUE)
    ) p7_sync_i (
        .clk(clk),
        .rst_b(rst_b),
        .pins_async(port7_pins_in),
        .sync_r(p7_sync)
    );

    // Reset to idle high so no false edge follows reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p7_prev_r <= `PIN_RESET_VALUE;
        end else begin
            p7_prev_r <= p7_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            first_port_read <= `OUT_RESET_VALUE;
        end else begin
            first_port_read <= first_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            second_port_read <= `OUT_RESET_VALUE;
        end else begin
            second_port_read <= second_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port7_read <= `PIN_RESET_VALUE;
        end else begin
            port7_read <= p7_sync;
        end
    end

    always_comb begin
        low_hit = |(p7_prev_r[`LOW_GROUP_MSB:`LOW_GROUP_LSB] & ~p7_sync[`LOW_GROUP_MSB:`LOW_GROUP_LSB]);
        mid_hit = |(p7_prev_r[`MID_GROUP_MSB:`MID_GROUP_LSB] ^ p7_sync[`MID_GROUP_MSB:`MID_GROUP_LSB]);
        if (single_pin_rising_sel) begin
            single_hit = ~p7_prev_r[`SINGLE_PIN_BIT] & p7_sync[`SINGLE_PIN_BIT];
        end else begin
            single_hit = p7_prev_r[`SINGLE_PIN_BIT] & ~p7_sync[`SINGLE_PIN_BIT];
        end
    end

    sticky_edge_flag low_flag_i (
        .clk(clk),
        .rst_b(rst_b),
        .hit(low_hit),
        .clear(irq_clear.low_group_falling_irq),
        .flag_r(low_flag)
    );

    sticky_edge_flag mid_flag_i (
        .clk(clk),
        .rst_b(rst_b),
        .hit(mid_hit),
        .clear(irq_clear.mid_group_edge_irq),
        .flag_r(mid_flag)
    );

    sticky_edge_flag single_flag_i (
        .clk(clk),
        .rst_b(rst_b),
        .hit(single_hit),
        .clear(irq_clear.single_pin_selectable_irq),
        .flag_r(single_flag)
    );

    assign irq_flags = {low_flag, mid_flag, single_flag};
endmodule

// One group of shared pins, registered so the pins never glitch
module shared_pin_drive #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] dir_out,
    input wire logic [WIDTH-1:0] lcd_sel,
    input wire logic [WIDTH-1:0] data_out,
    input wire logic [WIDTH-1:0] seg_drive,
    output logic [WIDTH-1:0] pins_out_r,
    output logic [WIDTH-1:0] pins_oe_b_r
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_out_r <= WIDTH'(`OUT_RESET_VALUE);
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (lcd_sel[i]) begin
                    pins_out_r[i] <= seg_drive[i];
                end else begin
                    pins_out_r[i] <= data_out[i];
                end
            end
        end
    end

    // A segment pin is always driven, whatever its direction bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_oe_b_r <= WIDTH'(`OE_B_RESET_VALUE);
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (lcd_sel[i]) begin
                    pins_oe_b_r[i] <= 1'b0;
                end else begin
                    pins_oe_b_r[i] <= ~dir_out[i];
                end
            end
        end
    end
endmodule

// Two flip-flops; only the second one is read outside
module pin_sync2 #(
    parameter int WIDTH = `PORT_WIDTH,
    parameter logic [WIDTH-1:0] RESET_VALUE = WIDTH'(`PIN_RESET_VALUE)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pins_async,
    output logic [WIDTH-1:0] sync_r
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= RESET_VALUE;
            sync_r <= RESET_VALUE;
        end else begin
            meta_r <= pins_async;
            sync_r <= meta_r;
        end
    end
endmodule

// Set beats clear so an edge in the clear cycle is kept
module sticky_edge_flag (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hit,
    input wire logic clear,
    output logic flag_r
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else if (hit) begin
            flag_r <= 1'b1;
        end else if (clear) begin
            flag_r <= 1'b0;
        end
    end
endmodule

// File: port_edge_regs.svh
`ifndef PORT_EDGE_REGS_SVH
`define PORT_EDGE_REGS_SVH
`define PORT_WIDTH 8
`define LOW_GROUP_LSB 0
`define LOW_GROUP_MSB 3
`define MID_GROUP_LSB 4
`define MID_GROUP_MSB 6
`define SINGLE_PIN_BIT 7
`define PIN_RESET_VALUE 8'hff
`define OUT_RESET_VALUE 8'h00
`define OE_B_RESET_VALUE 8'hff
`endif

// File: port_edge_pkg.sv
package port_edge_pkg;
    typedef struct packed {
        logic [7:0] dir_out;
        logic [7:0] lcd_sel;
        logic [7:0] data_out;
        logic [7:0] seg_drive;
    } port_ctrl_t;
    typedef struct packed {
        logic low_group_falling_irq;
        logic mid_group_edge_irq;
        logic single_pin_selectable_irq;
    } irq_flags_t;
endpackage

// File: port_edge_chk_sva.sv
`timescale 1ns/1ps
module port_edge_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire port_edge_pkg::port_ctrl_t first_ctrl,
    input wire port_edge_pkg::port_ctrl_t second_ctrl,
    input wire logic [7:0] first_shared_port_pins_out,
    input wire logic [7:0] first_shared_port_pins_oe_b,
    input wire logic [7:0] second_shared_port_pins_out,
    input wire logic [7:0] second_shared_port_pins_oe_b,
    input wire logic [7:0] port7_pins_in,
    input wire logic single_pin_rising_sel,
    input wire port_edge_pkg::irq_flags_t irq_clear,
    input wire port_edge_pkg::irq_flags_t irq_flags
);
    import port_edge_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence low_fall; |($past(port7_pins_in[3:0]) & ~port7_pins_in[3:0]); endsequence
    sequence mid_edge; $past(port7_pins_in[6:4]) != port7_pins_in[6:4]; endsequence
    sequence sel_edge; single_pin_rising_sel ? $rose(port7_pins_in[7]) : $fell(port7_pins_in[7]); endsequence
    chk_first_dir: assert property (
        first_shared_port_pins_oe_b == ~$past(first_ctrl.dir_out | first_ctrl.lcd_sel))
        else $error("first enable wrong");
    chk_second_dir: assert property (
        second_shared_port_pins_oe_b == ~$past(second_ctrl.dir_out | second_ctrl.lcd_sel))
        else $error("second enable wrong");
    chk_seg_share: assert property (first_shared_port_pins_out == $past(first_ctrl.lcd_sel & first_ctrl.seg_drive
        | ~first_ctrl.lcd_sel & first_ctrl.data_out)) else $error("pin drive wrong");
    chk_second_seg: assert property (second_shared_port_pins_out == $past(second_ctrl.lcd_sel & second_ctrl.seg_drive
        | ~second_ctrl.lcd_sel & second_ctrl.data_out)) else $error("second pin drive wrong");
    chk_low_fall: assert property (low_fall |-> ##[2:4] irq_flags.low_group_falling_irq) else $error("low flag late");
    chk_mid_edge: assert property (mid_edge |-> ##[2:4] irq_flags.mid_group_edge_irq) else $error("mid flag late");
    chk_sel_edge: assert property (
        sel_edge |-> ##[2:4] irq_flags.single_pin_selectable_irq) else $error("pin flag late");
    chk_flag_hold: assert property (irq_flags.mid_group_edge_irq && !irq_clear.mid_group_edge_irq
        |=> irq_flags.mid_group_edge_irq) else $error("flag dropped");
    chk_low_hold: assert property (irq_flags.low_group_falling_irq && !irq_clear.low_group_falling_irq
        |=> irq_flags.low_group_falling_irq) else $error("low flag dropped");
    chk_pin_hold: assert property (irq_flags.single_pin_selectable_irq && !irq_clear.single_pin_selectable_irq
        |=> irq_flags.single_pin_selectable_irq) else $error("pin flag dropped");
endmodule
bind port_edge_interrupts port_edge_chk port_edge_chk_i (.*);

// File: pin_source.sv
`timescale 1ns/1ps
module pin_source (
    input wire logic [7:0] drv,
    input wire logic [7:0] oe_b,
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    // Released pins show the outside source
    assign lvl = (drv & ~oe_b) | (ext & oe_b);
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import port_edge_pkg::*;
    logic clk = 0, rst_b = 0, single_pin_rising_sel = 0;
    port_ctrl_t first_ctrl = '0, second_ctrl = '0;
    irq_flags_t irq_clear = '0, irq_flags;
    logic [7:0] port7_pins_in = 8'hff, ext = 8'h81, first_shared_port_pins_in, second_shared_port_pins_in;
    logic [7:0] first_shared_port_pins_out, first_shared_port_pins_oe_b, second_shared_port_pins_out;
    logic [7:0] second_shared_port_pins_oe_b, first_port_read, second_port_read, port7_read;
    int bad_count = 0, total_checks = 0;
    port_edge_interrupts port_edge_interrupts_i (.*);
    pin_source first_src_i (.drv(first_shared_port_pins_out), .oe_b(first_shared_port_pins_oe_b), .ext(ext),
        .lvl(first_shared_port_pins_in));
    pin_source second_src_i (.drv(second_shared_port_pins_out), .oe_b(second_shared_port_pins_oe_b), .ext(ext),
        .lvl(second_shared_port_pins_in));
    initial forever #2.5 clk = ~clk;
    task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Waits past the three-edge latency, so a held flag also proves stickiness
    task automatic step(logic [7:0] v, logic [2:0] exp);
        port7_pins_in = v;
        repeat (6) @(negedge clk);
        check("irq_flags", {5'h0, irq_flags}, {5'h0, exp});
        check("port7_read", port7_read, v);
        irq_clear = 3'h7;
        @(negedge clk);
        irq_clear = 3'h0;
        @(negedge clk);
    endtask
    task automatic t_ports;
        first_ctrl = '{8'h5a, 8'h0f, 8'h33, 8'hc6};
        second_ctrl = '{8'ha5, 8'h0f, 8'h33, 8'hc6};
        repeat (4) @(negedge clk);
        check("first_oe_b", first_shared_port_pins_oe_b, 8'ha0);
        check("second_oe_b", second_shared_port_pins_oe_b, 8'h50);
        check("first_out", first_shared_port_pins_out, 8'h36);
        check("second_out", second_shared_port_pins_out, 8'h36);
        check("first_read", first_port_read, 8'h96);
        check("second_read", second_port_read, 8'h26);
        check("port7_read", port7_read, 8'hff);
    endtask
    task automatic t_low;
        for (int i = 0; i < 4; i++) begin
            step(~(8'h01 << i), 3'h4);
            step(8'hff, 3'h0);
        end
    endtask
    task automatic t_mid;
        for (int i = 4; i < 7; i++) begin
            step(~(8'h01 << i), 3'h2);
            step(8'hff, 3'h2);
        end
    endtask
    task automatic t_single;
        step(8'h7f, 3'h1);
        step(8'hff, 3'h0);
        single_pin_rising_sel = 1;
        step(8'h7f, 3'h0);
        step(8'hff, 3'h1);
    endtask
    // Clear lands in the very cycle the flag is set; the set must win
    task automatic t_race;
        port7_pins_in = 8'hfe;
        repeat (2) @(negedge clk);
        irq_clear = 3'h7;
        @(negedge clk);
        irq_clear = 3'h0;
        check("race_flags", {5'h0, irq_flags}, 8'h04);
        step(8'hff, 3'h4);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1;
        t_ports;
        t_low;
        t_mid;
        t_single;
        t_race;
        tally_and_finish;
    end
endmodule
